/* hw/pat_pkg.sv */
// constants for the page access trap logic
package pat_pkg;
   // access key codes that can raise a trap condition
   localparam logic [2:0] PAT_KEY_TRAP_WR   = 3'h1;
   localparam logic [2:0] PAT_KEY_TRAP_RW   = 3'h4;
   localparam logic [2:0] PAT_KEY_TRAP_WR5  = 3'h5;
   // bus cycle type encoding
   localparam logic [1:0] PAT_CYC_DATI      = 2'h0;
   localparam logic [1:0] PAT_CYC_DATIP     = 2'h1;
   localparam logic [1:0] PAT_CYC_DATO      = 2'h2;
   localparam logic [1:0] PAT_CYC_DATOB     = 2'h3;
   // trap vector in kernel space (octal 250)
   localparam logic [15:0] PAT_TRAP_VECTOR  = 16'h00a8;
   // clock and detect delay timing
   localparam int PAT_CLK_NS                = 25;
   localparam int PAT_DET_DLY_NS            = 50;
   localparam int PAT_DET_DLY_CYC           = (PAT_DET_DLY_NS + PAT_CLK_NS - 1) / PAT_CLK_NS;
   // axi register map
   localparam logic [3:0] PAT_ADDR_CTRL     = 4'h0;
   localparam logic [3:0] PAT_ADDR_STATUS   = 4'h4;
   localparam logic [3:0] PAT_ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] PAT_ADDR_IRQ_MASK = 4'hc;
   // field positions
   localparam int PAT_BIT_RELOC             = 0;
   localparam int PAT_BIT_TRAP_EN           = 9;
   localparam int PAT_BIT_DETECTED          = 12;
   localparam int PAT_IRQ_DETECT            = 0;
   localparam int PAT_IRQ_WRITTEN           = 1;
   localparam int PAT_IRQ_ATTN              = 2;
   localparam int PAT_IRQ_W                 = 3;
   localparam logic [1:0] PAT_RESP_OKAY     = 2'h0;
   localparam logic [1:0] PAT_RESP_SLVERR   = 2'h2;
endpackage : pat_pkg

/* hw/pat_trap_logic.sv */
// page access trap detection, descriptor logging and trap request
`timescale 1ns/10ps
`default_nettype none

module pat_trap_logic
#(
   parameter int DET_DLY_CYC = pat_pkg::PAT_DET_DLY_CYC
)
(
   input  wire logic        mclk,
   input  wire logic        rst,
   // processor timing and cycle information
   input  wire logic        busCycleT5,
   input  wire logic        pause_ts3_pulse,
   input  wire logic        pause_t4_pulse,
   input  wire logic [1:0]  busCycleType,
   input  wire logic [2:0]  access_key_field,
   input  wire logic        relocation_active,
   input  wire logic        unit_register_select_n,
   input  wire logic        abortFlag,
   input  wire logic        trapAck,
   // descriptor bits, trap request, trap vector, detected flag and interrupt
   output logic             descWrite,
   output logic             descAttnData,
   output logic             descWrtnData,
   output logic             trap_request_n,
   output logic [15:0]      trapVector,
   output logic             trap_detected_flag,
   output logic             irq,
   // axi4-lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   if (DET_DLY_CYC < 1 || DET_DLY_CYC > 255)
   begin : gBadDelay
      $error("DET_DLY_CYC out of range");
   end

   // ------------------------------------------------------------
   // key decode
   // ------------------------------------------------------------
   logic writeCycle;
   logic trap_key_match;
   logic trap_condition_clock;
   logic trapCondLatched_reg;
   logic writeLatched_reg;
   assign writeCycle = (busCycleType == pat_pkg::PAT_CYC_DATO)
                    || (busCycleType == pat_pkg::PAT_CYC_DATOB)
                    || (busCycleType == pat_pkg::PAT_CYC_DATIP);
   assign trap_key_match = ((access_key_field == pat_pkg::PAT_KEY_TRAP_WR) && writeCycle)
                        || (access_key_field == pat_pkg::PAT_KEY_TRAP_RW)
                        || ((access_key_field == pat_pkg::PAT_KEY_TRAP_WR5) && writeCycle);
   assign trap_condition_clock = trap_key_match && relocation_active
                              && unit_register_select_n;

   // capture the condition at the end of T5; the reference itself goes on
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         trapCondLatched_reg <= 1'b0;
         writeLatched_reg    <= 1'b0;
      end
      else if (busCycleT5)
      begin
         trapCondLatched_reg <= trap_condition_clock;
         writeLatched_reg    <= writeCycle && relocation_active && unit_register_select_n;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic        trap_enable_bit;
   logic        relocEnable_reg;
   logic [3:0]  irqStat_reg;
   logic [3:0]  irqMask_reg;
   logic        wrFire;
   logic        clrDetect;
   logic [31:0] wdataHeld_reg;
   logic [3:0]  waddrHeld_reg;
   logic [3:0]  wstrbHeld_reg;
   logic        awHave_reg;
   logic        wHave_reg;

   // ------------------------------------------------------------
   // trap detect, hold and delay
   // ------------------------------------------------------------
   logic       trap_hold_latch;
   logic       detect_delay;
   logic [7:0] dlyCnt_reg;
   logic       detSet;
   logic       holdSet;
   logic       preTrap;
   assign preTrap = trapCondLatched_reg && trap_enable_bit && !abortFlag
                 && !detect_delay;
   assign detSet  = pause_ts3_pulse && trapCondLatched_reg && !abortFlag;
   assign holdSet = detSet && trap_enable_bit && !detect_delay;
   assign trap_request_n = !(preTrap || trap_hold_latch);
   assign trapVector     = pat_pkg::PAT_TRAP_VECTOR;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         trap_detected_flag <= 1'b0;
      end
      else if (detSet)
      begin
         trap_detected_flag <= 1'b1;
      end
      else if (clrDetect)
      begin
         trap_detected_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         trap_hold_latch <= 1'b0;
      end
      else if (trapAck || abortFlag)
      begin
         trap_hold_latch <= 1'b0;
      end
      else if (holdSet)
      begin
         trap_hold_latch <= 1'b1;
      end
   end

   // detect delay follows the flag after the delay count
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dlyCnt_reg   <= 8'h00;
         detect_delay <= 1'b0;
      end
      else if (!trap_detected_flag)
      begin
         dlyCnt_reg   <= 8'h00;
         detect_delay <= 1'b0;
      end
      else if (!detect_delay)
      begin
         if (dlyCnt_reg == 8'(DET_DLY_CYC - 1))
         begin
            detect_delay <= 1'b1;
         end
         else
         begin
            dlyCnt_reg <= dlyCnt_reg + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // descriptor attention and written bits
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         descWrite    <= 1'b0;
         descAttnData <= 1'b0;
         descWrtnData <= 1'b0;
      end
      else
      begin
         descWrite    <= pause_t4_pulse && (trapCondLatched_reg || writeLatched_reg);
         descAttnData <= trapCondLatched_reg;
         descWrtnData <= writeLatched_reg;
      end
   end

   // ------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------
   assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
   assign s_axi_wready  = !wHave_reg && !s_axi_bvalid;
   assign wrFire        = awHave_reg && wHave_reg && !s_axi_bvalid;
   assign clrDetect     = wrFire && (waddrHeld_reg == pat_pkg::PAT_ADDR_CTRL)
                       && wstrbHeld_reg[1] && !wdataHeld_reg[pat_pkg::PAT_BIT_DETECTED];

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         awHave_reg    <= 1'b0;
         wHave_reg     <= 1'b0;
         waddrHeld_reg <= 4'h0;
         wdataHeld_reg <= 32'h0;
         wstrbHeld_reg <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= pat_pkg::PAT_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHave_reg    <= 1'b1;
            waddrHeld_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHave_reg     <= 1'b1;
            wdataHeld_reg <= s_axi_wdata;
            wstrbHeld_reg <= s_axi_wstrb;
         end
         if (wrFire)
         begin
            awHave_reg   <= 1'b0;
            wHave_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (waddrHeld_reg[1:0] == 2'h0) ? pat_pkg::PAT_RESP_OKAY
                                                         : pat_pkg::PAT_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // control bits: relocation enable and trap enable
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         relocEnable_reg <= 1'b0;
         trap_enable_bit <= 1'b0;
      end
      else if (wrFire && waddrHeld_reg == pat_pkg::PAT_ADDR_CTRL)
      begin
         if (wstrbHeld_reg[0])
         begin
            relocEnable_reg <= wdataHeld_reg[pat_pkg::PAT_BIT_RELOC];
         end
         if (wstrbHeld_reg[1])
         begin
            trap_enable_bit <= wdataHeld_reg[pat_pkg::PAT_BIT_TRAP_EN];
         end
      end
   end

   // sticky events, write one to clear, set wins
   logic [3:0] irqEvt;
   logic [3:0] irqClr;
   assign irqEvt = {1'b0, descWrite && descAttnData, descWrite && descWrtnData, detSet};
   assign irqClr = (wrFire && waddrHeld_reg == pat_pkg::PAT_ADDR_IRQ_STAT && wstrbHeld_reg[0])
                 ? wdataHeld_reg[3:0] : 4'h0;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         irqStat_reg <= 4'h0;
      end
      else
      begin
         irqStat_reg <= (irqStat_reg & ~irqClr) | irqEvt;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         irqMask_reg <= 4'h0;
      end
      else if (wrFire && waddrHeld_reg == pat_pkg::PAT_ADDR_IRQ_MASK && wstrbHeld_reg[0])
      begin
         irqMask_reg <= wdataHeld_reg[3:0];
      end
   end

   assign irq = |(irqStat_reg & irqMask_reg);

   // ------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= pat_pkg::PAT_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= pat_pkg::PAT_RESP_OKAY;
         s_axi_rdata  <= 32'h0;
         unique case (s_axi_araddr)
            pat_pkg::PAT_ADDR_CTRL:
            begin
               s_axi_rdata[pat_pkg::PAT_BIT_RELOC]    <= relocEnable_reg;
               s_axi_rdata[pat_pkg::PAT_BIT_TRAP_EN]  <= trap_enable_bit;
               s_axi_rdata[pat_pkg::PAT_BIT_DETECTED] <= trap_detected_flag;
            end
            pat_pkg::PAT_ADDR_STATUS:
            begin
               s_axi_rdata[3:0] <= {detect_delay, trap_hold_latch, trapCondLatched_reg,
                                    !trap_request_n};
            end
            pat_pkg::PAT_ADDR_IRQ_STAT:
            begin
               s_axi_rdata[3:0] <= irqStat_reg;
            end
            pat_pkg::PAT_ADDR_IRQ_MASK:
            begin
               s_axi_rdata[3:0] <= irqMask_reg;
            end
            default:
            begin
               s_axi_rresp <= pat_pkg::PAT_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : pat_trap_logic

`default_nettype wire

/* tb/pat_cpu_trap_model.sv */
// processor trap priority model, acknowledges after a set delay
`timescale 1ns/10ps
`default_nettype none
module pat_cpu_trap_model
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       pause_ts3_pulse,
   input  wire logic       trap_request_n,
   input  wire logic [3:0] ackDelay,
   output logic            trapAck,
   output logic            trapTaken
);
   logic [3:0] waitCnt;
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         trapTaken <= 1'b0;
         waitCnt   <= 4'h0;
      end
      else if (pause_ts3_pulse && !trap_request_n && !trapTaken)
      begin
         trapTaken <= 1'b1;
         waitCnt   <= ackDelay;
      end
      else if (waitCnt != 4'h0)
         waitCnt <= waitCnt - 4'h1;
      else
         trapTaken <= 1'b0;
   assign trapAck = trapTaken && waitCnt == 4'h0;
endmodule : pat_cpu_trap_model
`default_nettype wire

/* tb/pat_trap_properties.sv */
// assertions on the page access trap logic ports
`timescale 1ns/10ps
`default_nettype none
module pat_trap_properties
#(
   parameter int DET_DLY_CYC = 2
)
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       busCycleT5,
   input wire logic       pause_ts3_pulse,
   input wire logic       pause_t4_pulse,
   input wire logic [1:0] busCycleType,
   input wire logic [2:0] access_key_field,
   input wire logic       relocation_active,
   input wire logic       unit_register_select_n,
   input wire logic       abortFlag,
   input wire logic       trapAck,
   input wire logic       descWrite,
   input wire logic       descAttnData,
   input wire logic       descWrtnData,
   input wire logic       trap_request_n,
   input wire logic       trap_detected_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic       condReg;
   logic       wrReg;
   logic [7:0] flagCnt;
   wire logic  act = relocation_active && unit_register_select_n;
   // expected condition, latched at end of T5
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         condReg <= 1'b0;
         wrReg   <= 1'b0;
      end
      else if (busCycleT5)
      begin
         condReg <= act && (access_key_field == 3'h4 || (busCycleType != 2'h0
                    && (access_key_field == 3'h1 || access_key_field == 3'h5)));
         wrReg   <= act && busCycleType[1];
      end
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         flagCnt <= 8'h00;
      else
         flagCnt <= !trap_detected_flag ? 8'h00 : flagCnt + {7'h00, flagCnt != 8'hff};
   sequence sTrap;
      pause_ts3_pulse && condReg && !abortFlag;
   endsequence
   chk_reset_idle: assert property ($past(rst) |-> trap_request_n && !trap_detected_flag)
      else $error("trap state not idle after reset");
   chk_detect_set: assert property (sTrap |=> trap_detected_flag)
      else $error("detected flag not set");
   chk_no_detect: assert property (pause_ts3_pulse && !condReg && !trap_detected_flag
      |=> !trap_detected_flag) else $error("detected flag set without condition");
   chk_request_cause: assert property ($fell(trap_request_n) |-> condReg && !abortFlag)
      else $error("request without condition");
   chk_abort_release: assert property (abortFlag [*2] |-> trap_request_n)
      else $error("request kept through abort");
   chk_hold_keep: assert property (pause_ts3_pulse && !trap_request_n && !abortFlag
      && !trapAck |=> !trap_request_n) else $error("request not held");
   chk_delay_block: assert property (flagCnt > DET_DLY_CYC && trapAck
      |=> trap_request_n || !trap_detected_flag) else $error("gate open after detect");
   chk_attn_log: assert property (pause_t4_pulse && condReg |=> descWrite && descAttnData)
      else $error("attention bit not logged");
   chk_wrtn_log: assert property (pause_t4_pulse && wrReg |=> descWrite && descWrtnData)
      else $error("written bit not logged");
   chk_desc_when: assert property (descWrite |-> $past(pause_t4_pulse))
      else $error("descriptor write outside T4");
endmodule : pat_trap_properties
`default_nettype wire

/* tb/test_page_access_trap_logic.sv */
// self-checking bench for the page access trap logic
`timescale 1ns/10ps
`default_nettype none
module test_page_access_trap_logic;
   logic        mclk = 1'b0, rst = 1'b1, busCycleT5 = 1'b0;
   logic        pause_ts3_pulse = 1'b0, pause_t4_pulse = 1'b0, abortFlag = 1'b0;
   logic [1:0]  busCycleType = 2'h0, s_axi_bresp, s_axi_rresp, rs, t;
   logic [2:0]  access_key_field = 3'h0, k;
   logic        relocation_active = 1'b0, unit_register_select_n = 1'b1, c, en;
   logic        trapAck, descWrite, descAttnData, descWrtnData, trap_request_n;
   logic        trap_detected_flag, irq, trapTaken, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, ackDelay = 4'h1;
   logic [15:0] trapVector;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   int          mismatches = 0, numChecks = 0, n;
   always #12.5 mclk = ~mclk;
   pat_trap_logic #(.DET_DLY_CYC(2)) dut (.mclk, .rst, .busCycleT5, .pause_ts3_pulse,
      .pause_t4_pulse, .busCycleType, .access_key_field, .relocation_active,
      .unit_register_select_n, .abortFlag, .trapAck, .descWrite, .descAttnData, .descWrtnData,
      .trap_request_n, .trapVector, .trap_detected_flag, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pat_cpu_trap_model cpu (.mclk, .rst, .pause_ts3_pulse, .trap_request_n, .ackDelay,
      .trapAck, .trapTaken);
   task automatic finalReport;
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finalReport
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      numChecks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // ---------------------------------------------
   // bus cycles, entered just after a rising edge
   // ---------------------------------------------
   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
      logic aT, wT, bT;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      bT = 1'b0;
      for (n = 0; n < 40 && !bT; n++)
      begin
         @(negedge mclk);
         aT = s_axi_awvalid && s_axi_awready;
         wT = s_axi_wvalid && s_axi_wready;
         bT = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge mclk);
         if (aT) s_axi_awvalid <= 1'b0;
         if (wT) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge mclk);
      chk("write response", 1, bT);
      if (!bT) finalReport();
   endtask : axiWrite
   task automatic axiRead(input logic [3:0] a);
      logic aT, rT;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rT = 1'b0;
      for (n = 0; n < 40 && !rT; n++)
      begin
         @(negedge mclk);
         aT = s_axi_arvalid && s_axi_arready;
         rT = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge mclk);
         if (aT) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge mclk);
      chk("read response", 1, rT);
      if (!rT) finalReport();
   endtask : axiRead
   // bus cycle then pause; desc is {compare, write, attention, written}
   task automatic access(input logic [2:0] key, input logic [1:0] typ, input logic [1:0] sel,
                         input logic req, input logic flag, input logic [3:0] desc);
      access_key_field <= key;
      busCycleType <= typ;
      {relocation_active, unit_register_select_n} <= sel;
      busCycleT5 <= 1'b1;
      @(posedge mclk);
      busCycleT5 <= 1'b0;
      pause_ts3_pulse <= 1'b1;
      @(negedge mclk);
      chk("trap request", !req, trap_request_n);
      @(posedge mclk);
      pause_ts3_pulse <= 1'b0;
      pause_t4_pulse <= 1'b1;
      @(negedge mclk);
      chk("detected flag", flag, trap_detected_flag);
      @(posedge mclk);
      pause_t4_pulse <= 1'b0;
      @(negedge mclk);
      if (desc[3]) chk("descriptor", desc[2:0], {descWrite, descAttnData, descWrtnData});
      @(posedge mclk);
   endtask : access
   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("idle request", 1, trap_request_n);
      chk("trap vector", 16'h00a8, trapVector);
      axiRead(4'h0);
      chk("control reset", 0, rd);
      for (int i = 0; i < 32; i++)
      begin
         {k, t} = i[4:0];
         en = i[0];
         c = k == 3'h4 || (t != 2'h0 && (k == 3'h1 || k == 3'h5));
         axiWrite(4'h0, {22'h0, en, 9'h001});
         access(k, t, 2'h3, c && en, c, {t != 2'h1, c || t[1], c, t[1]});
      end
      access(3'h4, 2'h2, 2'h1, 0, 0, 4'h8);
      access(3'h4, 2'h2, 2'h2, 0, 0, 4'h8);
      axiRead(4'h0);
      chk("control", 32'h201, rd);
      abortFlag <= 1'b1;
      access(3'h4, 2'h0, 2'h3, 0, 0, 4'h0);
      abortFlag <= 1'b0;
      ackDelay <= 4'ha;
      access(3'h4, 2'h0, 2'h3, 1, 1, 4'he);
      @(negedge mclk);
      chk("held request", 0, trap_request_n);
      @(posedge mclk);
      axiRead(4'h4);
      chk("status", 32'hf, rd);
      for (n = 0; n < 20 && !trapAck; n++)
         @(negedge mclk);
      chk("acknowledge", 1, trapAck);
      if (!trapAck) finalReport();
      @(negedge mclk);
      chk("request after ack", 1, trap_request_n);
      @(posedge mclk);
      access(3'h4, 2'h0, 2'h3, 0, 1, 4'he);
      axiWrite(4'h0, 32'h1201);
      access(3'h4, 2'h0, 2'h3, 0, 1, 4'he);
      ackDelay <= 4'h1;
      axiWrite(4'h8, 32'hf);
      axiWrite(4'h0, 32'h201);
      access(3'h4, 2'h0, 2'h3, 1, 1, 4'he);
      axiRead(4'h8);
      chk("event status", 32'h5, rd);
      axiWrite(4'hc, 32'hf);
      chk("irq unmasked", 1, irq);
      axiWrite(4'hc, 32'h0);
      chk("irq mask", 0, irq);
      axiWrite(4'h8, 32'h5);
      axiRead(4'h8);
      chk("event cleared", 32'h0, rd);
      chk("irq cleared", 0, irq);
      axiWrite(4'h2, 32'h0);
      chk("misaligned write", 2'h2, rs);
      axiRead(4'h2);
      chk("unmapped resp", 2'h2, rs);
      chk("unmapped data", 0, rd);
      axiWrite(4'h0, 32'h201);
      ackDelay <= 4'hf;
      access(3'h4, 2'h0, 2'h3, 1, 1, 4'he);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk("request after reset", 1, trap_request_n);
      chk("flag after reset", 0, trap_detected_flag);
      @(posedge mclk);
      axiRead(4'h0);
      chk("control after reset", 0, rd);
      finalReport();
   end
endmodule : test_page_access_trap_logic
bind pat_trap_logic pat_trap_properties #(.DET_DLY_CYC(DET_DLY_CYC)) props (.mclk, .rst,
   .busCycleT5, .pause_ts3_pulse, .pause_t4_pulse, .busCycleType, .access_key_field,
   .relocation_active, .unit_register_select_n, .abortFlag, .trapAck, .descWrite,
   .descAttnData, .descWrtnData, .trap_request_n, .trap_detected_flag);
`default_nettype wire
